// ==== common/tccp_defs.svh ====
// constants for the two-channel capture/compare/pwm timer
// assumes inclusion by the package and the core only
// Notes on behaviour
// - seven bus clock divisions or external pin
// - active capture edge copies counter to channel
// - captured value is pre-edge count plus two
// - capture overwrites even when flag set
// - flag raises irq only when enabled
// - channel value registers not reset
// - compare match sets, clears or toggles pin
// - unbuffered value writes take effect immediately
// - pair link joins channels, channel 0 first
// - last written pair controls after overflow
// - linked: channel 0 control governs, 1 ignored
// - linked output on pin 0, pin 1 released
// - toggle on overflow forms pwm period
// - modulo 0x00FF undivided gives 256 cycles
// - value 0x0080 gives half period pulse
// - 16-bit up counter, free or modulo
// - mode 01 unbuffered, 10 buffered, link priority
// - no overflow toggle 0%, max duty without overflow toggle 100%
`ifndef TCCP_DEFS_SVH
`define TCCP_DEFS_SVH
`define TCCP_A_CTRL      4'h0
`define TCCP_A_COUNT     4'h1
`define TCCP_A_MOD       4'h2
`define TCCP_A_CH0_CS    4'h3
`define TCCP_A_CH0_VAL   4'h4
`define TCCP_A_CH1_CS    4'h5
`define TCCP_A_CH1_VAL   4'h6
`define TCCP_A_IRQ       4'h7
`define TCCP_PS_EXT      3'h7
`define TCCP_MOD_RESET   16'hFFFF
`define TCCP_CAP_ADJ     16'h0002
`define TCCP_CTRL_TOF    7
`define TCCP_CTRL_TOIE   6
`define TCCP_CTRL_STOP   5
`define TCCP_CTRL_TRST   4
`define TCCP_CS_FLAG     7
`define TCCP_CS_IE       6
`define TCCP_CS_MSB      5
`define TCCP_CS_MSA      4
`define TCCP_CS_ELSB     3
`define TCCP_CS_ELSA     2
`define TCCP_CS_TOV      1
`define TCCP_CS_MAX      0
`endif

// ==== common/tccp_pkg.sv ====
// types for the two-channel capture/compare/pwm timer
// assumes the defs header is found on the include path
package tccp_pkg;
  `include "tccp_defs.svh"
  typedef enum logic [1:0] {
    TCCP_MODE_CAPTURE,
    TCCP_MODE_COMPARE,
    TCCP_MODE_BUFFERED
  } tccp_mode_type;
endpackage

// ==== core/tccp_core.sv ====
// two-channel 16-bit capture/compare/pwm timer with avalon-mm slave
// assumes one 100 MHz clock, pins synchronous to it, sync reset
`timescale 1ns/1ps
`default_nettype none
`include "tccp_defs.svh"
module tccp_core #(
  parameter int PS_WIDTH = 3
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        external_count_clock_pin,
  input  wire logic        channel0_pin_in,
  input  wire logic        channel1_pin_in,
  output logic             channel0_pin_out,
  output logic             channel0_pin_oe_n,
  output logic             channel1_pin_out,
  output logic             channel1_pin_oe_n,
  output logic             irq
);
  import tccp_pkg::*;

  // registered answer: one wait cycle, reply at second edge
  logic        ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  cs_q [2];
  logic [7:0]  cs_d [2];
  logic [15:0] val_q [2];
  logic [15:0] val_d [2];
  logic [15:0] cnt_q, cnt_d, mod_q, mod_d;
  logic [6:0]  pre_q, pre_d;
  logic [1:0]  ext_q, ext_d;
  logic [1:0]  cap0_q, cap0_d, cap1_q, cap1_d;
  logic [1:0]  pin_q, pin_d;
  logic        act_q, act_d;
  logic        tof_arm_q, tof_arm_d;
  logic [15:0] cnt_prev_q, cnt_prev_d;

  function automatic tccp_mode_type mode_of(input logic [7:0] cs);
    if (cs[`TCCP_CS_MSB])
      mode_of = TCCP_MODE_BUFFERED;
    else if (cs[`TCCP_CS_MSA])
      mode_of = TCCP_MODE_COMPARE;
    else
      mode_of = TCCP_MODE_CAPTURE;
  endfunction

  function automatic logic edge_hit(input logic [7:0] cs,
                                    input logic [1:0] s);
    logic rise;
    logic fall;
    rise = s[0] & ~s[1];
    fall = ~s[0] & s[1];
    unique case ({cs[`TCCP_CS_ELSB], cs[`TCCP_CS_ELSA]})
      2'h1: edge_hit = rise;
      2'h2: edge_hit = fall;
      2'h3: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic cmp_level(input logic [7:0] cs, input logic p);
    unique case ({cs[`TCCP_CS_ELSB], cs[`TCCP_CS_ELSA]})
      2'h1: cmp_level = ~p;
      2'h2: cmp_level = 1'b0;
      2'h3: cmp_level = 1'b1;
      default: cmp_level = p;
    endcase
  endfunction

  logic        req, wr, tick, ovf, linked;
  logic [6:0]  pre_mask;
  logic [15:0] cnt_nxt;
  logic [1:0]  cap_hit, cmp_hit;
  logic [2:0]  ps;

  always_comb begin
    req = (avs_read | avs_write) & ~ack_q;
    wr = avs_write & ~ack_q;
    ps = ctrl_q[PS_WIDTH-1:0];
    linked = cs_q[0][`TCCP_CS_MSB];
    // seven divided rates, ext pin counted on rising edge
    // divide by 2^ps: tick when the low ps prescaler bits are all ones
    pre_mask = (7'h01 << ps) - 7'h01;
    if (ps == `TCCP_PS_EXT)
      tick = ext_q[0] & ~ext_q[1];
    else
      tick = ((pre_q & pre_mask) == pre_mask);
    tick = tick & ~ctrl_q[`TCCP_CTRL_STOP];
    ovf = tick & (cnt_q == mod_q);
    // compare on the count being entered, while the overflow tests the current count
    cnt_nxt = ovf ? 16'h0000 : cnt_q + 16'h0001;
    // capture edges on double-flopped inputs, first flop against second
    cap_hit[0] = mode_of(cs_q[0]) == TCCP_MODE_CAPTURE
               && edge_hit(cs_q[0], cap0_q);
    cap_hit[1] = !linked && mode_of(cs_q[1]) == TCCP_MODE_CAPTURE
               && edge_hit(cs_q[1], cap1_q);
    cmp_hit[0] = tick && mode_of(cs_q[0]) != TCCP_MODE_CAPTURE
               && cnt_nxt == val_q[linked ? act_q : 1'b0];
    cmp_hit[1] = tick && !linked
               && mode_of(cs_q[1]) == TCCP_MODE_COMPARE
               && cnt_nxt == val_q[1];
  end

  always_comb begin
    pre_d = pre_q + 7'h01;
    ext_d = {ext_q[0], external_count_clock_pin};
    cap0_d = {cap0_q[0], channel0_pin_in};
    cap1_d = {cap1_q[0], channel1_pin_in};
    cnt_prev_d = cnt_q;
    cnt_d = cnt_q;
    if (ovf)
      cnt_d = 16'h0000;
    else if (tick)
      cnt_d = cnt_q + 16'h0001;
    ctrl_d = ctrl_q;
    mod_d = mod_q;
    cs_d = cs_q;
    val_d = val_q;
    act_d = linked ? act_q : 1'b0;
    tof_arm_d = tof_arm_q;
    pin_d = pin_q;
    ack_d = req;
    // read data stands until the next read answer
    rd_d = rd_q;
    if (req && avs_read) begin
      unique case (avs_address)
        `TCCP_A_CTRL: begin
          rd_d = {24'h00_0000, ctrl_q};
          tof_arm_d = ctrl_q[`TCCP_CTRL_TOF];
        end
        `TCCP_A_COUNT: rd_d = {16'h0000, cnt_q};
        `TCCP_A_MOD: rd_d = {16'h0000, mod_q};
        `TCCP_A_CH0_CS: rd_d = {24'h00_0000, cs_q[0]};
        `TCCP_A_CH0_VAL: rd_d = {16'h0000, val_q[0]};
        `TCCP_A_CH1_CS: rd_d = {24'h00_0000, cs_q[1]};
        `TCCP_A_CH1_VAL: rd_d = {16'h0000, val_q[1]};
        `TCCP_A_IRQ: rd_d = {31'h0000_0000, irq};
        default: rd_d = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (avs_address)
        `TCCP_A_CTRL: begin
          // flag only cleared by 0 after reading it set
          ctrl_d = {ctrl_q[`TCCP_CTRL_TOF] &
                    (avs_writedata[`TCCP_CTRL_TOF] | ~tof_arm_q),
                    avs_writedata[6:5], 1'b0, 1'b0, avs_writedata[2:0]};
          if (avs_writedata[`TCCP_CTRL_TRST]) begin
            cnt_d = 16'h0000;
            pre_d = 7'h00;
          end
          tof_arm_d = 1'b0;
        end
        `TCCP_A_MOD: mod_d = avs_writedata[15:0];
        `TCCP_A_CH0_CS, `TCCP_A_CH1_CS: begin
          cs_d[avs_address[2]] = {cs_q[avs_address[2]][`TCCP_CS_FLAG] &
                                  avs_writedata[`TCCP_CS_FLAG],
                                  avs_writedata[6:0]};
          if (avs_address[2])
            cs_d[1][`TCCP_CS_MSB] = 1'b0;
        end
        `TCCP_A_CH0_VAL: begin
          val_d[0] = avs_writedata[15:0];
          if (linked)
            pin_d[1] = 1'b0;  // remember pair 0 as last written
        end
        `TCCP_A_CH1_VAL: begin
          val_d[1] = avs_writedata[15:0];
          if (linked)
            pin_d[1] = 1'b1;
        end
        default: ;
      endcase
    end
    // hardware set wins over software clear
    if (ovf)
      ctrl_d[`TCCP_CTRL_TOF] = 1'b1;
    if (ovf && linked)
      act_d = pin_q[1];
    for (int i = 0; i < 2; i++) begin
      if (cap_hit[i]) begin
        // pipeline already costs two cycles; add two back
        val_d[i] = cnt_prev_q + `TCCP_CAP_ADJ;
        cs_d[i][`TCCP_CS_FLAG] = 1'b1;
      end
      if (cmp_hit[i])
        cs_d[i][`TCCP_CS_FLAG] = 1'b1;
    end
    // pin 0 drives both the single and linked function
    for (int i = 0; i < 2; i++) begin
      if (i == 0 || !linked) begin
        if (mode_of(cs_q[i]) != TCCP_MODE_CAPTURE) begin
          if (cs_q[i][`TCCP_CS_MAX] && !cs_q[i][`TCCP_CS_TOV])
            pin_d[i] = 1'b1;
          else if (cmp_hit[i])
            pin_d[i] = cmp_level(cs_q[i], pin_q[i]);
          else if (ovf && cs_q[i][`TCCP_CS_TOV])
            pin_d[i] = ~pin_q[i];
        end
      end
    end
    if (!rst_n) begin
      ack_d = 1'b0;
      rd_d = 32'h0000_0000;
      ctrl_d = 8'h00;
      mod_d = `TCCP_MOD_RESET;
      cnt_d = 16'h0000;
      pre_d = 7'h00;
      pin_d = 2'h0;
      act_d = 1'b0;
      tof_arm_d = 1'b0;
      cs_d[0] = 8'h00;
      cs_d[1] = 8'h00;
      ext_d = 2'h0;
      cap0_d = 2'h0;
      cap1_d = 2'h0;
      cnt_prev_d = 16'h0000;
    end
  end

  always_ff @(posedge clk) begin
    ack_q <= ack_d;
    rd_q <= rd_d;
    ctrl_q <= ctrl_d;
    mod_q <= mod_d;
    cnt_q <= cnt_d;
    cnt_prev_q <= cnt_prev_d;
    pre_q <= pre_d;
    pin_q <= pin_d;
    act_q <= act_d;
    tof_arm_q <= tof_arm_d;
    cs_q <= cs_d;
    ext_q <= ext_d;
    cap0_q <= cap0_d;
    cap1_q <= cap1_d;
  end

  // values keep contents across reset
  always_ff @(posedge clk) begin
    val_q <= val_d;
  end

  always_comb begin
    avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    avs_readdata = rd_q;
    channel0_pin_out = pin_q[0];
    channel0_pin_oe_n = mode_of(cs_q[0]) == TCCP_MODE_CAPTURE;
    channel1_pin_out = pin_q[1] & ~linked;
    // released for general use while linked
    channel1_pin_oe_n = linked
      || mode_of(cs_q[1]) == TCCP_MODE_CAPTURE;
    irq = (cs_q[0][`TCCP_CS_FLAG] & cs_q[0][`TCCP_CS_IE])
        | (~linked & cs_q[1][`TCCP_CS_FLAG] & cs_q[1][`TCCP_CS_IE])
        | (ctrl_q[`TCCP_CTRL_TOF] & ctrl_q[`TCCP_CTRL_TOIE]);
  end
endmodule
`default_nettype wire

// ==== verification/tccp_core_properties.sv ====
// port checker for the timer core
// assumes it is bound into every core instance
`timescale 1ns/1ps
`default_nettype none
module tccp_core_properties (
  input wire logic        clk, rst_n, avs_read, avs_write,
  input wire logic [3:0]  avs_address,
  input wire logic [31:0] avs_writedata, avs_readdata,
  input wire logic        avs_waitrequest, irq, external_count_clock_pin,
  input wire logic        channel0_pin_in, channel1_pin_in,
  input wire logic        channel0_pin_out, channel0_pin_oe_n,
  input wire logic        channel1_pin_out, channel1_pin_oe_n
);
  logic req;
  logic wr_seen_q;
  logic wr_seen_d;
  assign req = avs_read | avs_write;
  always_comb wr_seen_d = wr_seen_q | (avs_write & ~avs_waitrequest);
  always_ff @(posedge clk) wr_seen_q <= rst_n & wr_seen_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_wait_idle_low: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  a_wait_on_rise: assert property ($rose(req) |-> avs_waitrequest)
    else $error("new request not held");
  a_wait_one_cycle: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer not one cycle after take");
  a_wait_never_two: assert property (not (avs_waitrequest ##1 avs_waitrequest))
    else $error("waitrequest high two cycles");
  a_rdata_stands: assert property (!(req && !avs_waitrequest) |-> $stable(avs_readdata))
    else $error("readdata moved without answer");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[3] |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_pins: assert property ($rose(rst_n) |-> channel0_pin_oe_n && channel1_pin_oe_n && !channel0_pin_out && !channel1_pin_out)
    else $error("pins not released by reset");
  a_irq_needs_enable: assert property (!wr_seen_q |-> !irq)
    else $error("irq without any enable written");
  c_read_ack: cover property (avs_read && !avs_waitrequest);
  c_irq_up: cover property ($rose(irq));
  c_pin0_drive: cover property (!channel0_pin_oe_n && $rose(channel0_pin_out));
endmodule
bind tccp_core tccp_core_properties u_props (.clk(clk), .rst_n(rst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_address(avs_address),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq),
  .external_count_clock_pin(external_count_clock_pin),
  .channel0_pin_in(channel0_pin_in), .channel1_pin_in(channel1_pin_in),
  .channel0_pin_out(channel0_pin_out), .channel0_pin_oe_n(channel0_pin_oe_n),
  .channel1_pin_out(channel1_pin_out), .channel1_pin_oe_n(channel1_pin_oe_n));
`default_nettype wire

// ==== verification/tccp_core_test.sv ====
// self-checking bench for the timer core
// assumes pins model and bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module tccp_core_test;
  import tccp_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q, c;
  logic        avs_waitrequest, irq, ext_on = 1'b0, drv0 = 1'b0, drv1 = 1'b0;
  logic        ext_pin, pin0, pin1, out0, out1, oe0_n, oe1_n;
  int          miscompares = 0, cmp_count = 0, hi, per, v, n;
  int          pss[4] = '{0, 1, 2, 7};
  always #5 clk = ~clk;
  tccp_core u_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_count_clock_pin(ext_pin), .channel0_pin_in(pin0),
    .channel1_pin_in(pin1), .channel0_pin_out(out0), .channel0_pin_oe_n(oe0_n),
    .channel1_pin_out(out1), .channel1_pin_oe_n(oe1_n), .irq(irq));
  tccp_pins_model u_pins (.clk(clk), .ext_on(ext_on), .drv0(drv0),
    .drv1(drv1), .out0(out0), .out1(out1), .oe0_n(oe0_n), .oe1_n(oe1_n),
    .pin0(pin0), .pin1(pin1), .ext_pin(ext_pin));
  function automatic int scale(input int ps);
    return (ps == 7) ? 8 : (1 << ps);
  endfunction
  task automatic tick();
    @(posedge clk);
    drv1 <= 1'($urandom);
  endtask
  // request stands until waitrequest seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input int d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask
  // one full high pulse and the period around it, as seen on the wire
  task automatic pulse();
    while (pin0 !== 1'b0) tick();
    while (pin0 !== 1'b1) tick();
    hi = 0;
    while (pin0 === 1'b1) begin tick(); hi++; end
    per = hi;
    while (pin0 === 1'b0) begin tick(); per++; end
  endtask
  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #900000;
    miscompares++;
    final_report();
  end
  initial begin
    v = $urandom(36963);
    reset_dut();
    bus(0, 4'h2, 0); chk(q, 32'hFFFF);
    v = 8 + $urandom_range(0, 7);
    bus(1, v, $urandom); bus(0, v, 0); chk(q, 0);
    bus(1, 4'h0, 'h30); bus(1, 4'h3, 'h04);
    drv0 <= 1'b1;
    repeat (4) tick();
    bus(0, 4'h4, 0); chk(q, 2);
    bus(0, 4'h3, 0); chk(q[7], 1'b1); chk(irq, 1'b0);
    drv0 <= 1'b0;
    bus(1, 4'h0, 0);
    repeat ($urandom_range(10, 300)) tick();
    bus(1, 4'h0, 'h20); bus(0, 4'h1, 0); c = (q + 2) & 'hFFFF;
    drv0 <= 1'b1;
    repeat (4) tick();
    bus(0, 4'h4, 0); chk(q, c);
    bus(1, 4'h3, 'hC4); tick(); chk(irq, 1'b1);
    bus(1, 4'h3, 'h44); tick(); chk(irq, 1'b0);
    reset_dut();
    bus(0, 4'h4, 0); chk(q, c);
    // compare clears at value, overflow toggles; software side kept
    foreach (pss[i]) begin
      v = (i == 0) ? 'h80 : $urandom_range(1, 254);
      ext_on <= (pss[i] == 7);
      bus(1, 4'h0, 'h30); bus(1, 4'h2, 'hFF); // counter held while set up
      bus(1, 4'h4, v);
      bus(1, 4'h3, 'h1A); bus(1, 4'h0, pss[i]);
      pulse();
      chk(per, 256 * scale(pss[i]));
      chk(hi, v * scale(pss[i]));
    end
    ext_on <= 1'b0;
    bus(1, 4'h0, 'h30); bus(1, 4'h4, 'h40); bus(1, 4'h3, 'h2A);
    bus(1, 4'h5, 'h1A); bus(1, 4'h0, 0);
    pulse(); chk(hi, 'h40);
    bus(1, 4'h6, 'h20);
    pulse(); chk(hi, 'h20);
    chk({oe1_n, oe0_n}, 2'b10);
    for (int m = 0; m < 2; m++) begin
      bus(1, 4'h3, 'h18 | m);
      repeat (300) tick();
      n = 0;
      repeat (512) begin tick(); n += (pin0 !== m[0]); end
      chk(n, 0);
    end
    final_report();
  end
endmodule
`default_nettype wire

// ==== verification/tccp_pins_model.sv ====
// pin-side model: channel pin wires and external count clock
// assumes bench levels drive released pins, ext clock only when asked
`timescale 1ns/1ps
`default_nettype none
module tccp_pins_model (
  input  wire logic clk,
  input  wire logic ext_on,
  input  wire logic drv0,
  input  wire logic drv1,
  input  wire logic out0,
  input  wire logic out1,
  input  wire logic oe0_n,
  input  wire logic oe1_n,
  output logic      pin0,
  output logic      pin1,
  output logic      ext_pin
);
  logic [1:0] ph_q = 2'h0;
  // wire level: device wins while its enable is low
  assign pin0 = oe0_n ? drv0 : out0;
  assign pin1 = oe1_n ? drv1 : out1;
  // count clock of eight bus cycles, still when unused
  always @(posedge clk) begin
    ph_q <= ext_on ? ph_q + 2'h1 : 2'h0;
    ext_pin <= !ext_on ? 1'b0 : ((ph_q == 2'h3) ? ~ext_pin : ext_pin);
  end
endmodule
`default_nettype wire
